// ===== rtl/rcd_pkg.sv
package rcd_pkg;
    // Bus geometry
    localparam int          ADDR_W      = 4;
    localparam int          DATA_W      = 32;
    localparam logic [3:0]  OFS_CMD     = 4'h0;
    localparam logic [3:0]  OFS_STATUS  = 4'h4;
    localparam logic [3:0]  OFS_CTRL    = 4'h8;
    localparam logic [3:0]  BE_FULL     = 4'hF;
    localparam logic        CTRL_EN_RST = 1'b1;
    localparam int          CTRL_EN_BIT = 0;
    localparam int          ST_SYNC_BIT = 0;
    localparam int          ST_BUSY_BIT = 1;
    localparam int          ST_FLAG_BIT = 2;
    localparam int          ST_EN_BIT   = 3;

    // Command word fields
    localparam int TYPE_HI = 31;
    localparam int TYPE_LO = 24;
    localparam int SUB_HI  = 23;
    localparam int SUB_LO  = 16;
    localparam int PRM_HI  = 15;
    localparam int SYNC_VB_BIT  = 0;
    localparam int LINE_AXIS_Y  = 0;
    localparam int LINE_NO_END  = 1;
    localparam int LINE_PAT_CLR = 2;
    localparam int LINE_AA      = 3;
    localparam int LINE_FAST    = 4;
    localparam int VTX_SEL_HI   = 1;

    // Type codes
    localparam logic [7:0] T_POINT       = 8'h00;
    localparam logic [7:0] T_POINT_DEPTH = 8'h01;
    localparam logic [7:0] T_LINE        = 8'h02;
    localparam logic [7:0] T_FLINE       = 8'h03;
    localparam logic [7:0] T_FLINE_PK    = 8'h04;
    localparam logic [7:0] T_TRAP        = 8'h05;
    localparam logic [7:0] T_FTRI        = 8'h06;
    localparam logic [7:0] T_FTRI_PK     = 8'h07;
    localparam logic [7:0] T_RECT        = 8'h09;
    localparam logic [7:0] T_BITMAP      = 8'h0B;
    localparam logic [7:0] T_COPY        = 8'h0D;
    localparam logic [7:0] T_ALT_COPY    = 8'h0F;
    localparam logic [7:0] T_TEX         = 8'h11;
    localparam logic [7:0] T_TEX_LOCAL   = 8'h13;
    localparam logic [7:0] T_ALPHA_COPY  = 8'h1F;
    localparam logic [7:0] T_VTX         = 8'h70;
    localparam logic [7:0] T_VTX_PK      = 8'h71;
    localparam logic [7:0] T_DRAW        = 8'hF0;
    localparam logic [7:0] T_REGSET      = 8'hF1;
    localparam logic [7:0] T_SYNC        = 8'hFC;
    localparam logic [7:0] T_IRQ         = 8'hFD;
    localparam logic [7:0] T_NOP         = 8'hFF;

    // Sub-command codes
    localparam logic [7:0] S_POINT       = 8'h00;
    localparam logic [7:0] S_POINT_DEPTH = 8'h01;
    localparam logic [2:0] S_LINE_PFX    = 3'h1;
    localparam logic [7:0] S_SOLID_FILL  = 8'h41;
    localparam logic [7:0] S_BLOCK_DRAW  = 8'h42;
    localparam logic [7:0] S_CHAR_BITMAP = 8'h43;
    localparam logic [7:0] S_COPY_UL     = 8'h44;
    localparam logic [7:0] S_COPY_LR     = 8'h47;
    localparam logic [7:0] S_TEX_PATTERN = 8'h48;
    localparam logic [7:0] S_TILE        = 8'h49;
    localparam logic [7:0] S_TRAP_RIGHT  = 8'h60;
    localparam logic [7:0] S_TRAP_LEFT   = 8'h61;
    localparam logic [7:0] S_FAN         = 8'h62;
    localparam logic [7:0] S_FLAG_FAN    = 8'h63;
    localparam logic [7:0] S_FRAME_FLUSH = 8'hC1;
    localparam logic [7:0] S_DEPTH_FLUSH = 8'hC2;
    localparam logic [7:0] S_SHAPE_BEGIN = 8'hE0;
    localparam logic [7:0] S_SHAPE_END   = 8'hE1;
    localparam logic [7:0] S_FLAG_CLEAR  = 8'hE2;
    localparam logic [7:0] S_NORMAL      = 8'hFF;

    // Parameter words that follow each first word
    localparam logic [7:0] N_POINT       = 8'h02;
    localparam logic [7:0] N_POINT_DEPTH = 8'h03;
    localparam logic [7:0] N_LINE        = 8'h05;
    localparam logic [7:0] N_FAST_2W     = 8'h02;
    localparam logic [7:0] N_PACKED      = 8'h01;
    localparam logic [7:0] N_BLOCK       = 8'h02;
    localparam logic [7:0] N_COPY        = 8'h03;
    localparam logic [7:0] N_NONE        = 8'h00;

    typedef enum logic [1:0] {
        RCD_IDLE  = 2'b00,
        RCD_PARAM = 2'b01,
        RCD_SYNC  = 2'b10
    } rcd_phase_t;
endpackage : rcd_pkg

// ===== rtl/rcd_decoder.sv
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
// What this block does
// - Decode the eight primitive draw type codes, point through packed fast triangle.
// - Decode block type codes: rectangle, bitmap, copies, texture loads, alpha copy.
// - Decode control types: vertex sets, draw, register set, sync, interrupt, no-op.
// - Line sub-commands: axis Y, no end point, pattern clear, anti-alias, fast line.
// - Fast line starts at vertex 1 when the select bit is set, else vertex 0.
// - Decode block sub-commands: fill, block draw, bitmap, four copies, texture, tile.
// - Decode trapezoid right/left, fan and flagged fan sub-commands.
// - Decode flushes, shape begin/end, flag clear, normal; shape end clears flag.
// - The four copy sub-commands choose the starting corner.
// - Rectangle with flag clear clears the flag; with fill draws solid rectangle.
// - Bitmap type with bitmap sub-command draws a character bitmap.
// - Vertex set normal loads a vertex; shape begin starts bounding rectangle.
// - Interrupt command raises a request toward the host.
// - Sync stalls all following words until the selected event.
// - Sync flag bit 0 selects vertical blank; bits 4..1 are reserved zero.
// - Flag bit clear means no wait; set means wait for vertical blank.
// - Parameter words are stored as they arrive; the last in the same cycle the command executes.
// - Register set writes count words to consecutive registers from the start address.
module rcd_decoder (
    input  wire logic                       i_clk,
    input  wire logic                       i_resetn,
    input  wire logic [rcd_pkg::ADDR_W-1:0] i_address,
    input  wire logic                       i_read,
    input  wire logic                       i_write,
    input  wire logic [rcd_pkg::DATA_W-1:0] i_writedata,
    input  wire logic [3:0]                 i_byteenable,
    output logic      [rcd_pkg::DATA_W-1:0] o_readdata,
    output logic                            o_waitrequest,
    input  wire logic                       i_vertical_blank_event,
    output logic                            o_exec,
    output logic      [7:0]                 o_exec_type,
    output logic      [7:0]                 o_exec_sub,
    output logic      [15:0]                o_exec_low,
    output logic                            o_param_we,
    output logic                            o_reg_we,
    output logic      [15:0]                o_out_index,
    output logic      [rcd_pkg::DATA_W-1:0] o_out_data,
    output logic                            o_start_vertex1,
    output logic      [1:0]                 o_copy_corner,
    output logic                            o_flush_frame,
    output logic                            o_flush_depth,
    output logic                            o_shape_begin,
    output logic                            o_vertex_load,
    output logic                            o_shape_flag,
    output logic                            o_host_irq
);
    import rcd_pkg::*;

    typedef struct packed {
        rcd_phase_t   phase;
        logic         en;
        logic         wait_r;
        logic [31:0]  rdata;
        logic [7:0]   ctype;
        logic [7:0]   csub;
        logic [15:0]  clow;
        logic [7:0]   left;
        logic [15:0]  idx;
        logic         exec;
        logic [7:0]   ex_type;
        logic [7:0]   ex_sub;
        logic [15:0]  ex_low;
        logic         pwe;
        logic         rwe;
        logic [15:0]  out_idx;
        logic [31:0]  out_data;
        logic         v1;
        logic [1:0]   corner;
        logic         fl_frame;
        logic         fl_depth;
        logic         sh_begin;
        logic         vtx_load;
        logic         sh_flag;
        logic         irq;
        logic         vb1;
        logic         vb2;
        logic         vb3;
    } rcd_state_t;

    rcd_state_t c_r;
    rcd_state_t c_nxt;

    function automatic logic [7:0] rcd_param_words(input logic [7:0] t);
        case (t)
            T_POINT:                          rcd_param_words = N_POINT;
            T_POINT_DEPTH:                    rcd_param_words = N_POINT_DEPTH;
            T_LINE:                           rcd_param_words = N_LINE;
            T_FLINE, T_FTRI, T_VTX:           rcd_param_words = N_FAST_2W;
            T_FLINE_PK, T_FTRI_PK, T_VTX_PK:  rcd_param_words = N_PACKED;
            T_RECT, T_BITMAP, T_TEX:          rcd_param_words = N_BLOCK;
            T_COPY, T_ALT_COPY, T_TEX_LOCAL,
            T_ALPHA_COPY:                     rcd_param_words = N_COPY;
            default:                          rcd_param_words = N_NONE;
        endcase
    endfunction : rcd_param_words

    function automatic logic rcd_valid(input logic [7:0] t, input logic [7:0] s);
        case (t)
            T_POINT:            rcd_valid = (s == S_POINT);
            T_POINT_DEPTH:      rcd_valid = (s == S_POINT_DEPTH);
            T_LINE:             rcd_valid = (s[7:5] == S_LINE_PFX) && !s[LINE_FAST];
            T_FLINE, T_FLINE_PK: rcd_valid = (s[7:5] == S_LINE_PFX) && s[LINE_FAST];
            T_TRAP:             rcd_valid = (s == S_TRAP_RIGHT) || (s == S_TRAP_LEFT);
            T_FTRI, T_FTRI_PK:  rcd_valid = (s == S_FAN) || (s == S_FLAG_FAN);
            T_RECT:             rcd_valid = (s == S_SOLID_FILL) || (s == S_FLAG_CLEAR)
                                            || (s == S_BLOCK_DRAW);
            T_BITMAP:           rcd_valid = (s == S_CHAR_BITMAP);
            T_COPY, T_ALT_COPY: rcd_valid = (s >= S_COPY_UL) && (s <= S_COPY_LR);
            T_TEX, T_TEX_LOCAL: rcd_valid = (s == S_TEX_PATTERN) || (s == S_TILE);
            T_VTX, T_VTX_PK:    rcd_valid = (s == S_NORMAL) || (s == S_SHAPE_BEGIN);
            T_DRAW:             rcd_valid = (s == S_FRAME_FLUSH) || (s == S_DEPTH_FLUSH)
                                            || (s == S_SHAPE_END);
            T_ALPHA_COPY, T_REGSET, T_SYNC, T_IRQ, T_NOP: rcd_valid = 1'b1;
            default:            rcd_valid = 1'b0;
        endcase
    endfunction : rcd_valid

    ////////////////////////////////////////////////////////////////////////////
    logic        req;
    logic        hit_cmd;
    logic        stall;
    logic        accept;
    logic        vb_edge;
    logic        e_go;
    logic [7:0]  e_type;
    logic [7:0]  e_sub;
    logic [15:0] e_low;

    assign req     = i_read | i_write;
    assign hit_cmd = i_write && (i_address == OFS_CMD);
    // Back-pressure instead of a queue: the host simply waits out the sync
    assign stall   = hit_cmd && (c_r.phase == RCD_SYNC);
    assign accept  = hit_cmd && c_r.wait_r && !stall && c_r.en && (i_byteenable == BE_FULL);
    assign vb_edge = c_r.vb2 && !c_r.vb3;

    always_comb begin
        c_nxt          = c_r;
        e_go           = 1'b0;
        e_type         = c_r.ctype;
        e_sub          = c_r.csub;
        e_low          = c_r.clow;
        c_nxt.exec     = 1'b0;
        c_nxt.pwe      = 1'b0;
        c_nxt.rwe      = 1'b0;
        c_nxt.fl_frame = 1'b0;
        c_nxt.fl_depth = 1'b0;
        c_nxt.sh_begin = 1'b0;
        c_nxt.vtx_load = 1'b0;
        c_nxt.irq      = 1'b0;
        c_nxt.vb1      = i_vertical_blank_event;
        c_nxt.vb2      = c_r.vb1;
        c_nxt.vb3      = c_r.vb2;
        if ((c_r.phase == RCD_SYNC) && vb_edge) begin
            c_nxt.phase = RCD_IDLE;
        end

        // Bus slave: one wait cycle, then a single low cycle of waitrequest
        if (!c_r.wait_r) begin
            c_nxt.wait_r = 1'b1;
        end else if (req && !stall) begin
            c_nxt.wait_r = 1'b0;
            c_nxt.rdata  = 32'h0000_0000;
            if (i_read && (i_address == OFS_STATUS)) begin
                c_nxt.rdata[ST_SYNC_BIT] = (c_r.phase == RCD_SYNC);
                c_nxt.rdata[ST_BUSY_BIT] = (c_r.phase == RCD_PARAM);
                c_nxt.rdata[ST_FLAG_BIT] = c_r.sh_flag;
                c_nxt.rdata[ST_EN_BIT]   = c_r.en;
                c_nxt.rdata[15:8]        = c_r.ex_type;
                c_nxt.rdata[23:16]       = c_r.ex_sub;
            end else if (i_read && (i_address == OFS_CTRL)) begin
                c_nxt.rdata[CTRL_EN_BIT] = c_r.en;
            end
            if (i_write && (i_address == OFS_CTRL) && i_byteenable[0]) begin
                c_nxt.en = i_writedata[CTRL_EN_BIT];
            end
        end

        // Word parser
        if (accept) begin
            if (c_r.phase == RCD_IDLE) begin
                c_nxt.ctype = i_writedata[TYPE_HI:TYPE_LO];
                c_nxt.csub  = i_writedata[SUB_HI:SUB_LO];
                c_nxt.clow  = i_writedata[PRM_HI:0];
                c_nxt.idx   = 16'h0000;
                e_type      = i_writedata[TYPE_HI:TYPE_LO];
                e_sub       = i_writedata[SUB_HI:SUB_LO];
                e_low       = i_writedata[PRM_HI:0];
                if (e_type == T_REGSET) begin
                    c_nxt.left = e_sub;
                    c_nxt.idx  = e_low;
                end else begin
                    c_nxt.left = rcd_param_words(e_type);
                end
                if (c_nxt.left != 8'h00) begin
                    c_nxt.phase = RCD_PARAM;
                end else begin
                    e_go = (e_type != T_REGSET);
                end
            end else begin
                c_nxt.out_data = i_writedata;
                c_nxt.out_idx  = c_r.idx;
                c_nxt.idx      = c_r.idx + 16'h0001;
                c_nxt.left     = c_r.left - 8'h01;
                if (c_r.ctype == T_REGSET) begin
                    c_nxt.rwe = 1'b1;
                end else begin
                    c_nxt.pwe = 1'b1;
                end
                if (c_r.left == 8'h01) begin
                    c_nxt.phase = RCD_IDLE;
                    e_go        = (c_r.ctype != T_REGSET);
                end
            end
        end

        // Execution of a complete command; unknown codes fall through quietly
        if (e_go && rcd_valid(e_type, e_sub)) begin
            c_nxt.exec    = !((e_type == T_NOP) || (e_type == T_SYNC) || (e_type == T_REGSET));
            c_nxt.ex_type = e_type;
            c_nxt.ex_sub  = e_sub;
            c_nxt.ex_low  = e_low;
            c_nxt.v1      = ((e_type == T_FLINE) || (e_type == T_FLINE_PK)) && e_sub[0];
            c_nxt.corner  = e_sub[1:0];
            c_nxt.irq     = (e_type == T_IRQ);
            if ((e_type == T_SYNC) && e_low[SYNC_VB_BIT]) begin
                c_nxt.phase = RCD_SYNC;
            end
            c_nxt.fl_frame = (e_type == T_DRAW) && (e_sub == S_FRAME_FLUSH);
            c_nxt.fl_depth = (e_type == T_DRAW) && (e_sub == S_DEPTH_FLUSH);
            c_nxt.sh_begin = ((e_type == T_VTX) || (e_type == T_VTX_PK))
                             && (e_sub == S_SHAPE_BEGIN);
            c_nxt.vtx_load = ((e_type == T_VTX) || (e_type == T_VTX_PK))
                             && (e_sub == S_NORMAL);
            if (((e_type == T_FTRI) || (e_type == T_FTRI_PK)) && (e_sub == S_FLAG_FAN)) begin
                c_nxt.sh_flag = 1'b1;
            end else if (((e_type == T_DRAW) && (e_sub == S_SHAPE_END))
                         || ((e_type == T_RECT) && (e_sub == S_FLAG_CLEAR))) begin
                c_nxt.sh_flag = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            c_r        <= '0;
            c_r.phase  <= RCD_IDLE;
            c_r.en     <= CTRL_EN_RST;
            c_r.wait_r <= 1'b1;
        end else begin
            c_r <= c_nxt;
        end
    end

    assign o_readdata      = c_r.rdata;
    assign o_waitrequest   = c_r.wait_r;
    assign o_exec          = c_r.exec;
    assign o_exec_type     = c_r.ex_type;
    assign o_exec_sub      = c_r.ex_sub;
    assign o_exec_low      = c_r.ex_low;
    assign o_param_we      = c_r.pwe;
    assign o_reg_we        = c_r.rwe;
    assign o_out_index     = c_r.out_idx;
    assign o_out_data      = c_r.out_data;
    assign o_start_vertex1 = c_r.v1;
    assign o_copy_corner   = c_r.corner;
    assign o_flush_frame   = c_r.fl_frame;
    assign o_flush_depth   = c_r.fl_depth;
    assign o_shape_begin   = c_r.sh_begin;
    assign o_vertex_load   = c_r.vtx_load;
    assign o_shape_flag    = c_r.sh_flag;
    assign o_host_irq      = c_r.irq;

    ////////////////////////////////////////////////////////////////////////////
    logic idle_first;
    assign idle_first = accept && (c_r.phase == RCD_IDLE);

    a_irq_raise: assert property (@(posedge i_clk) disable iff (!i_resetn)
        idle_first && (i_writedata[TYPE_HI:TYPE_LO] == T_IRQ) |=> o_host_irq ##1 !o_host_irq)
        else $error("interrupt command did not pulse the host request");
    a_sync_stall: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (c_r.phase == RCD_SYNC) && hit_cmd |=> o_waitrequest)
        else $error("command word taken during sync wait");
    a_sync_vertical_blank_event: assert property (@(posedge i_clk) disable iff (!i_resetn)
        idle_first && (i_writedata[TYPE_HI:TYPE_LO] == T_SYNC) && i_writedata[SYNC_VB_BIT]
        |=> (c_r.phase == RCD_SYNC))
        else $error("sync with blank flag did not wait");
    a_sync_nowait: assert property (@(posedge i_clk) disable iff (!i_resetn)
        idle_first && (i_writedata[TYPE_HI:TYPE_LO] == T_SYNC) && !i_writedata[SYNC_VB_BIT]
        |=> (c_r.phase == RCD_IDLE))
        else $error("sync without flag waited");
    a_point_params: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_exec && (o_exec_type == T_POINT) |-> o_param_we && (o_out_index == 16'h0001))
        else $error("point executed before its parameter words");
    a_regset_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
        accept && (c_r.phase == RCD_PARAM) && (c_r.ctype == T_REGSET)
        |=> o_reg_we && (o_out_data == $past(i_writedata)) && (o_out_index == $past(c_r.idx)))
        else $error("register set word not forwarded");
    a_fast_vertex: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_exec && (o_exec_type == T_FLINE) |-> (o_start_vertex1 == o_exec_sub[0]))
        else $error("fast line start vertex wrong");
    a_unknown_quiet: assert property (@(posedge i_clk) disable iff (!i_resetn)
        idle_first && (i_writedata[TYPE_HI:TYPE_LO] == 8'h08) |=> !o_exec && (c_r.phase == RCD_IDLE))
        else $error("unlisted type had an effect");
    a_shape_end: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_exec && (o_exec_type == T_DRAW) && (o_exec_sub == S_SHAPE_END) |-> !o_shape_flag)
        else $error("shape end left the flag set");
    a_copy_corner: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_exec && (o_exec_type == T_COPY) |-> (o_copy_corner == o_exec_sub[1:0]))
        else $error("copy corner mismatch");

    c_sync_release: cover property (@(posedge i_clk) disable iff (!i_resetn)
        (c_r.phase == RCD_SYNC) ##1 (c_r.phase == RCD_IDLE));
    c_regset_two: cover property (@(posedge i_clk) disable iff (!i_resetn) o_reg_we ##[1:8] o_reg_we);
    c_line_exec: cover property (@(posedge i_clk) disable iff (!i_resetn) o_exec && (o_exec_type == T_LINE));
endmodule : rcd_decoder

// ===== bench/rcd_host_model.sv
`timescale 1ns/100ps
module rcd_host_model (
    input  wire logic        i_clk,
    input  wire logic        i_req,
    input  wire logic        i_rd,
    input  wire logic [3:0]  i_adr,
    input  wire logic [31:0] i_dat,
    input  wire logic        i_waitrequest,
    input  wire logic [31:0] i_readdata,
    output logic             o_read,
    output logic             o_write,
    output logic      [3:0]  o_address,
    output logic      [31:0] o_writedata,
    output logic      [31:0] o_rdata,
    output logic             o_done
);
    initial begin
        {o_read, o_write, o_address, o_writedata, o_rdata, o_done} = '0;
    end
    // Request held until waitrequest is seen low
    always @(posedge i_clk) begin
        o_done <= 1'b0;
        if (o_read || o_write) begin
            if (!i_waitrequest) begin
                o_read      <= 1'b0;
                o_write     <= 1'b0;
                o_rdata     <= i_readdata;
                o_done      <= 1'b1;
                o_writedata <= ~o_writedata; // Released data must not look valid
            end
        end else if (i_req && !o_done) begin
            o_read      <= i_rd;
            o_write     <= !i_rd;
            o_address   <= i_adr;
            o_writedata <= i_dat;
        end
    end
endmodule : rcd_host_model

// ===== bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import rcd_pkg::*;
    logic        i_clk = 0, i_resetn = 0, i_vertical_blank_event = 0, req = 0, rd = 0;
    logic        rd_w, wr_w, wt, done, ex, pwe, rwe, sv1, ff, fd, sb, vl, sf, irq;
    logic [3:0]  adr = 0, a_w;
    logic [31:0] dat = 0, d_w, rq, od, rdat, w, p;
    logic [15:0] oi, el;
    logic [7:0]  et, es;
    logic [1:0]  cc;
    logic [39:0] xq [$];
    logic [48:0] pq [$];
    int          num_errors = 0, checks = 0, cyc = 0, seed = 32'h2FBC;
    logic [31:0] cmds [26] = '{32'h00000000, 32'h01010000, 32'h02280000, 32'h03310001, 32'h04300000, 32'h05600000,
        32'h06620000, 32'h07630000, 32'h09E20000, 32'h0B430000, 32'h0D450000, 32'h0F470000, 32'h11480000,
        32'h13490000, 32'h70FF0000, 32'hF0C10000, 32'hFD000000, 32'hFC000000, 32'hF1020010, 32'h08000000,
        32'h71E00000, 32'h06630000, 32'hF0E10000, 32'hFF000000, 32'h09410000, 32'hF0C20000};
    int          np [26] = '{2, 3, 5, 2, 1, 0, 2, 1, 2, 2, 3, 3, 2, 3, 2, 0, 0, 0, 2, 0, 1, 2, 0, 0, 2, 0};
    rcd_decoder DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_address(a_w), .i_read(rd_w), .i_write(wr_w),
        .i_writedata(d_w), .i_byteenable(4'hF), .o_readdata(rq), .o_waitrequest(wt), .i_vertical_blank_event(i_vertical_blank_event),
        .o_exec(ex), .o_exec_type(et), .o_exec_sub(es), .o_exec_low(el), .o_param_we(pwe), .o_reg_we(rwe),
        .o_out_index(oi), .o_out_data(od), .o_start_vertex1(sv1), .o_copy_corner(cc), .o_flush_frame(ff),
        .o_flush_depth(fd), .o_shape_begin(sb), .o_vertex_load(vl), .o_shape_flag(sf), .o_host_irq(irq));
    rcd_host_model host (.i_clk(i_clk), .i_req(req), .i_rd(rd), .i_adr(adr), .i_dat(dat), .i_waitrequest(wt),
        .i_readdata(rq), .o_read(rd_w), .o_write(wr_w), .o_address(a_w), .o_writedata(d_w), .o_rdata(rdat),
        .o_done(done));
    initial forever #2.5 i_clk = ~i_clk;
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic r, input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        req <= 1'b1;
        {rd, adr, dat} <= {r, a, d};
        @(posedge i_clk);
        while (done !== 1'b1) @(posedge i_clk);
        req <= 1'b0;
    endtask : bus
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////////////
    // Output watcher; empty queue pops zero, so a stray pulse is caught too
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            give_verdict();
        end
        if (ex === 1'b1) chk({sv1, et, es, cc, ff, fd, sb, vl, irq, el}, xq.pop_front());
        if (pwe === 1'b1 || rwe === 1'b1) chk({rwe, oi, od}, pq.pop_front());
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge i_clk);
        i_resetn <= 1'b1;
        for (int i = 0; i < 26; i++) begin
            w = cmds[i];
            if (!(w[31:24] inside {8'h08, T_NOP, T_REGSET, T_SYNC})) begin
                xq.push_back({(w[31:24] inside {T_FLINE, T_FLINE_PK}) && w[16], w[31:16], w[17:16],
                    w[31:16] == {T_DRAW, S_FRAME_FLUSH}, w[31:16] == {T_DRAW, S_DEPTH_FLUSH},
                    w[31:16] inside {{T_VTX, S_SHAPE_BEGIN}, {T_VTX_PK, S_SHAPE_BEGIN}},
                    w[31:16] inside {{T_VTX, S_NORMAL}, {T_VTX_PK, S_NORMAL}}, w[31:24] == T_IRQ,
                    w[15:0]});
            end
            bus(1'b0, OFS_CMD, w);
            for (int k = 0; k < np[i]; k++) begin
                p = $random(seed);
                pq.push_back({w[31:24] == T_REGSET, (w[31:24] == T_REGSET) ? w[15:0] + k[15:0] : k[15:0], p});
                bus(1'b0, OFS_CMD, p);
            end
            if ((w[31:24] inside {T_FTRI, T_FTRI_PK})
                    || (w[31:16] inside {{T_DRAW, S_SHAPE_END}, {T_RECT, S_FLAG_CLEAR}})) begin
                chk(sf, w[23:16] == S_FLAG_FAN);
            end
            $display("test %0d done", i);
        end
        bus(1'b0, OFS_CMD, {T_SYNC, 24'h000001});
        fork
            bus(1'b0, OFS_CMD, {T_NOP, 24'h0});
            begin
                repeat (20) @(posedge i_clk);
                chk({done, wt}, 2'b01);
                i_vertical_blank_event <= 1'b1;
            end
        join
        i_vertical_blank_event <= 1'b0;
        bus(1'b0, OFS_CTRL, 32'h0);
        bus(1'b0, OFS_CMD, {T_IRQ, 24'h0});
        bus(1'b0, OFS_CTRL, 32'h1);
        bus(1'b1, OFS_STATUS, 32'h0);
        chk({rdat[ST_EN_BIT], rdat[ST_SYNC_BIT], rdat[15:8]}, {2'b10, T_NOP});
        bus(1'b1, 4'hC, 32'h0);
        chk(rdat, 32'h0);
        $display("test registers done");
        repeat (3) @(posedge i_clk);
        give_verdict();
    end
endmodule : tb_top
